// ==== core/alu_defs.svh ====
// Constants for the accumulator ALU subset: widths, flag positions, resets
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define ALU_DATA_W 8
`define ALU_ADDR_W 7
`define ALU_ACC_RST 8'h00
`define ALU_FLAG_C 0
`define ALU_FLAG_HC 1
`define ALU_FLAG_Z 2
`define ALU_DEST_ACC 1'b0
`define ALU_DEST_FILE 1'b1
`endif

// ==== core/alu_pkg.sv ====
// Types for the accumulator ALU subset
package alu_pkg;
   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_ADD_LIT = 3'b001,
      OP_MASK_LIT = 3'b010,
      OP_ADD_FILE = 3'b011,
      OP_MASK_FILE = 3'b100,
      OP_ADDC_FILE = 3'b101,
      OP_ASR_FILE = 3'b110
   } alu_op_t;
endpackage

// ==== core/alu_adder.sv ====
// Eight-bit adder with carry-in, carry-out and half-carry
`timescale 1ns/1ps
`include "alu_defs.svh"
module alu_adder #(
   parameter int WIDTH = `ALU_DATA_W
)(
   input wire logic [WIDTH-1:0] a_i,
   input wire logic [WIDTH-1:0] b_i,
   input wire logic cin_i,
   output logic [WIDTH-1:0] sum_o,
   output logic cout_o,
   output logic half_o
);
   logic [4:0] low_sum;
   logic [WIDTH-4:0] high_sum;

   // Half-carry needs the nibble boundary, so add in two pieces
   always_comb
   begin
      low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
      high_sum = {1'b0, a_i[WIDTH-1:4]} + {1'b0, b_i[WIDTH-1:4]}
         + {{(WIDTH-4){1'b0}}, low_sum[4]};
      sum_o = {high_sum[WIDTH-5:0], low_sum[3:0]};
      cout_o = high_sum[WIDTH-4];
      half_o = low_sum[4];
   end
endmodule

// ==== core/accumulator_alu_subset.sv ====
// Accumulator ALU datapath for a subset of add, mask and shift operations
`timescale 1ns/1ps
`include "alu_defs.svh"
// Function
// - Add literal to accumulator, flags C HC Z
// - AND literal into accumulator, only Z
// - Add accumulator and file, dest selects target
// - AND accumulator with file, only Z
// - Add accumulator, file and carry flag
// - Arithmetic shift right file, bit0 to carry
module accumulator_alu_subset
   import alu_pkg::*;
#(
   parameter int WIDTH = `ALU_DATA_W,
   parameter int ADDR_W = `ALU_ADDR_W
)(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic exec_i,
   input wire alu_op_t op_i,
   input wire logic [WIDTH-1:0] literal_i,
   input wire logic [ADDR_W-1:0] file_addr_i,
   input wire logic dest_i,
   input wire logic [WIDTH-1:0] file_data_i,
   output logic [WIDTH-1:0] acc_o,
   output logic carry_flag_o,
   output logic half_carry_flag_o,
   output logic zero_flag_o,
   output logic file_we_o,
   output logic [ADDR_W-1:0] file_waddr_o,
   output logic [WIDTH-1:0] file_wdata_o
);
   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   // The half-carry split in the adder assumes exactly one byte
   if (WIDTH != 8)
   begin : g_bad_width
      $error("accumulator_alu_subset: WIDTH must be 8");
   end

   // A file address needs at least one bit
   if (ADDR_W < 1)
   begin : g_bad_addr
      $error("accumulator_alu_subset: ADDR_W must be positive");
   end

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   // Accumulator and its next value
   logic [WIDTH-1:0] acc_q;
   logic [WIDTH-1:0] acc_d;

   // Status flags and their next values
   logic c_q;
   logic c_d;
   logic hc_q;
   logic hc_d;
   logic z_q;
   logic z_d;

   // Registered write port toward the file registers
   logic we_q;
   logic we_d;
   logic [ADDR_W-1:0] waddr_q;
   logic [ADDR_W-1:0] waddr_d;
   logic [WIDTH-1:0] wdata_q;
   logic [WIDTH-1:0] wdata_d;

   // Datapath nets
   logic [WIDTH-1:0] operand;
   logic [WIDTH-1:0] add_b;
   logic [WIDTH-1:0] add_sum;
   logic [WIDTH-1:0] result;
   logic add_cin;
   logic add_cout;
   logic add_half;
   logic fwd_hit;
   logic is_file;
   logic wr_file;

   ////////////////////////////////////////////////////////////////////////
   // Operand select for the shared adder
   // The file write is registered, so the file still holds the old byte
   // in the cycle after a write; forwarding the pending byte avoids a
   // stale operand when two operations touch one address back to back.
   always_comb
   begin
      fwd_hit = we_q && (waddr_q == file_addr_i);
      operand = fwd_hit ? wdata_q : file_data_i;
      is_file = (op_i != OP_ADD_LIT) && (op_i != OP_MASK_LIT);
      add_b = (op_i == OP_ADD_LIT) ? literal_i : operand;
      add_cin = (op_i == OP_ADDC_FILE) ? c_q : 1'b0;
   end

   alu_adder #(.WIDTH(WIDTH)) u_adder (
      .a_i(acc_q),
      .b_i(add_b),
      .cin_i(add_cin),
      .sum_o(add_sum),
      .cout_o(add_cout),
      .half_o(add_half)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result and flag next state; flags not named by an op hold
   always_comb
   begin
      acc_d = acc_q;
      c_d = c_q;
      hc_d = hc_q;
      z_d = z_q;
      result = acc_q;
      wr_file = 1'b0;
      we_d = 1'b0;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      if (exec_i)
      begin
         unique case (op_i)
            OP_ADD_LIT, OP_ADD_FILE, OP_ADDC_FILE:
            begin
               result = add_sum;
               c_d = add_cout;
               hc_d = add_half;
            end
            OP_MASK_LIT:
               result = acc_q & literal_i;
            OP_MASK_FILE:
               result = acc_q & operand;
            OP_ASR_FILE:
            begin
               // Sign bit is kept so signed values halve correctly
               result = {operand[WIDTH-1], operand[WIDTH-1:1]};
               c_d = operand[0];
            end
            default:
               result = acc_q;
         endcase
         if (op_i != OP_NONE)
         begin
            z_d = (result == '0);
            // Literal ops always land in the accumulator
            wr_file = is_file && (dest_i == `ALU_DEST_FILE);
            if (wr_file)
            begin
               we_d = 1'b1;
               waddr_d = file_addr_i;
               wdata_d = result;
            end
            else
            begin
               acc_d = result;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers; the write strobe lasts one cycle per operation
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acc_q <= `ALU_ACC_RST;
         c_q <= 1'b0;
         hc_q <= 1'b0;
         z_q <= 1'b0;
         we_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
      end
      else
      begin
         acc_q <= acc_d;
         c_q <= c_d;
         hc_q <= hc_d;
         z_q <= z_d;
         we_q <= we_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs come straight from the registers above
   assign acc_o = acc_q;
   assign carry_flag_o = c_q;
   assign half_carry_flag_o = hc_q;
   assign zero_flag_o = z_q;
   assign file_we_o = we_q;
   assign file_waddr_o = waddr_q;
   assign file_wdata_o = wdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions on the registered results
   // Add literal leaves the truncated sum in the accumulator
   property p_add_lit_acc;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i == OP_ADD_LIT)
      |=> (acc_q == $past(acc_q) + $past(literal_i)) && !we_q;
   endproperty
   a_add_lit_acc: assert property (p_add_lit_acc)
      else $error("add literal result wrong");

   // Mask literal changes no carry flags
   property p_mask_lit_flags;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i == OP_MASK_LIT)
      |=> (acc_q == ($past(acc_q) & $past(literal_i)))
         && $stable(c_q) && $stable(hc_q);
   endproperty
   a_mask_lit_flags: assert property (p_mask_lit_flags)
      else $error("mask literal result or flags wrong");

   // A file destination writes the file and leaves the accumulator
   property p_file_dest_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i != OP_NONE && is_file && dest_i == `ALU_DEST_FILE)
      |=> we_q && (waddr_q == $past(file_addr_i)) && $stable(acc_q);
   endproperty
   a_file_dest_write: assert property (p_file_dest_write)
      else $error("file destination not written");

   // Mask with file keeps carry and half-carry
   property p_mask_file_flags;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i == OP_MASK_FILE)
      |=> $stable(c_q) && $stable(hc_q);
   endproperty
   a_mask_file_flags: assert property (p_mask_file_flags)
      else $error("mask with file touched carry flags");

   // Add with carry into the accumulator counts the old carry
   property p_addc_sum;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i == OP_ADDC_FILE && dest_i == `ALU_DEST_ACC)
      |=> ({c_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(operand)}
         + {8'h00, $past(c_q)});
   endproperty
   a_addc_sum: assert property (p_addc_sum)
      else $error("add with carry sum wrong");

   // Shift right moves the old low bit into carry, half-carry holds
   property p_asr_carry;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i == OP_ASR_FILE)
      |=> (c_q == $past(operand[0])) && $stable(hc_q);
   endproperty
   a_asr_carry: assert property (p_asr_carry)
      else $error("shift right carry wrong");

   // Zero flag follows the result of every operation
   property p_zero_flag;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (exec_i && op_i != OP_NONE)
      |=> (z_q == ($past(result) == 8'h00));
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag wrong");

   // No write strobe without an operation
   property p_idle_no_write;
      @(posedge mclk_i) disable iff (!rst_b_i)
      !exec_i |=> !we_q;
   endproperty
   a_idle_no_write: assert property (p_idle_no_write)
      else $error("file written while idle");
endmodule

// ==== tb/file_mem.sv ====
// Behavioural file register memory facing the ALU
`timescale 1ns/1ps
module file_mem (
   input wire logic mclk_i,
   input wire logic we_i,
   input wire logic [6:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [6:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_q [128];
   // Seeded so that no read is ever unknown
   initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 37);
   assign rdata_o = mem_q[raddr_i];
   always @(posedge mclk_i)
      if (we_i) mem_q[waddr_i] <= wdata_i;
endmodule

// ==== tb/accumulator_alu_subset_tb.sv ====
// Self-checking bench for the accumulator ALU subset
`timescale 1ns/1ps
`include "alu_defs.svh"
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin \
   bad_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module accumulator_alu_subset_tb;
   import alu_pkg::*;
   logic mclk_i = 0, rst_b_i = 0, exec_i = 0, dest_i = 0, we, c, hc, z;
   logic cf, hf, zf, pend = 0;
   alu_op_t op_i = OP_NONE;
   logic [7:0] lit = 0, fd, acc_o, wd, acc = `ALU_ACC_RST, m [128];
   logic [6:0] fa = 0, wa;
   logic [10:0] q [$];
   int bad_count, comparisons;
   always #2.5 mclk_i = ~mclk_i;
   accumulator_alu_subset accumulator_alu_subset_inst (.mclk_i(mclk_i),
      .rst_b_i(rst_b_i), .exec_i(exec_i), .op_i(op_i), .literal_i(lit),
      .file_addr_i(fa), .dest_i(dest_i), .file_data_i(fd), .acc_o(acc_o),
      .carry_flag_o(cf), .half_carry_flag_o(hf), .zero_flag_o(zf),
      .file_we_o(we), .file_waddr_o(wa), .file_wdata_o(wd));
   file_mem file_mem_inst (.mclk_i(mclk_i), .we_i(we), .waddr_i(wa),
      .wdata_i(wd), .raddr_i(fa), .rdata_o(fd));
   ////////////////////////////////////////////////////////////////////////
   // Drive one operation and note the state it should leave behind
   task automatic step(alu_op_t o);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] f, r;
      logic ci;
      @(negedge mclk_i);
      op_i = o;
      lit = 8'($urandom);
      fa = 7'($urandom);
      dest_i = 1'($urandom);
      exec_i = 1;
      f = (o == OP_ADD_LIT || o == OP_MASK_LIT) ? lit : m[fa];
      ci = (o == OP_ADDC_FILE) ? c : 1'b0;
      s = {1'b0, acc} + f + ci;
      h = acc[3:0] + f[3:0] + ci;
      case (o)
         OP_MASK_LIT, OP_MASK_FILE: r = acc & f;
         OP_ASR_FILE:
         begin
            r = {f[7], f[7:1]};
            c = f[0];
         end
         default:
         begin
            r = s[7:0];
            c = s[8];
            hc = h[4];
         end
      endcase
      z = (r == 8'h00);
      // Literal forms always land in the accumulator
      if (dest_i && o > OP_MASK_LIT) m[fa] = r;
      else acc = r;
      q.push_back({acc, c, hc, z});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Results show one edge after the operation is taken
   always @(posedge mclk_i) pend <= exec_i;
   always @(negedge mclk_i)
      if (pend && q.size() > 0)
         `chk({acc_o, cf, hf, zf}, q.pop_front())
   task automatic print_verdict;
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 128; i++) m[i] = 8'(i * 37);
      void'($urandom(69));
      repeat (5) @(negedge mclk_i);
      rst_b_i = 1;
      `chk(acc_o, `ALU_ACC_RST)
      // Every operation in turn, then a random back-to-back stream
      for (int o = 1; o < 7; o++) step(alu_op_t'(o));
      repeat (400) step(alu_op_t'($urandom_range(6, 1)));
      @(negedge mclk_i);
      exec_i = 0;
      repeat (3) @(negedge mclk_i);
      print_verdict;
   end
   initial
   begin
      #20000;
      bad_count++;
      print_verdict;
   end
endmodule
